// [core/ntw_pkg.sv]
// ----------------------------------------------------------------------
// Shared constants and types for the tuning word register bank
// ----------------------------------------------------------------------
package ntw_pkg;

	// Register access port widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [11:0] OFS_INTERP = 12'h112;
	localparam logic [11:0] OFS_UPDATE = 12'h113;
	localparam logic [11:0] OFS_TW0 = 12'h114;
	localparam logic [11:0] OFS_TW1 = 12'h115;

	// Reset values
	localparam logic [2:0] RST_INTERP = 3'h1;
	localparam logic [7:0] RST_TW_BYTE = 8'h00;
	localparam logic [7:0] RST_READ = 8'h00;

	// Field positions in the handshake register
	localparam int BIT_REQ = 0;
	localparam int BIT_ACK = 1;

	// Interpolation factor field position and codes
	localparam int INTERP_LSB = 0;
	localparam int INTERP_MSB = 2;
	localparam logic [2:0] INTERP_1X = 3'h0;
	localparam logic [2:0] INTERP_2X = 3'h1;
	localparam logic [2:0] INTERP_4X = 3'h3;
	localparam logic [2:0] INTERP_8X = 3'h4;

	// Rate codes presented to the datapath: one-hot, or all zero for no rate
	localparam logic [3:0] RATE_1X = 4'h1;
	localparam logic [3:0] RATE_2X = 4'h2;
	localparam logic [3:0] RATE_4X = 4'h4;
	localparam logic [3:0] RATE_8X = 4'h8;
	localparam logic [3:0] RATE_NONE = 4'h0;

	// Low two bytes of the frequency tuning word, byte 0 least significant
	typedef struct packed {
		logic [7:0] byte1;
		logic [7:0] byte0;
	} ntw_word_t;

	// One register access from the serial control port
	typedef struct packed {
		logic write;
		logic read;
		logic [11:0] addr;
		logic [7:0] wdata;
	} ntw_access_t;

	// Handshake states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACKED = 2'b10
	} ntw_state_t;

endpackage

// [core/ntw_update_handshake.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Update request handshake: rising edge to transfer pulse and acknowledge
// ----------------------------------------------------------------------
module ntw_update_handshake
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic tuning_update_request,
	output logic transfer_pulse,
	output logic tuning_update_acknowledge
);

	// Handshake state
	ntw_pkg::ntw_state_t state;

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ntw_pkg::ST_IDLE;
		end
		else
		begin
			case (state)
				ntw_pkg::ST_IDLE:
				begin
					// Request seen high after being low: transfer now
					if (tuning_update_request)
					begin
						state <= ntw_pkg::ST_ACKED;
					end
				end
				ntw_pkg::ST_ACKED:
				begin
					// Host lowered the request: re-arm, drop acknowledge
					if (!tuning_update_request)
					begin
						state <= ntw_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state <= ntw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// One-cycle transfer strobe on the rising edge of the request
	assign transfer_pulse = (state == ntw_pkg::ST_IDLE)
		&& tuning_update_request;

	// Acknowledge straight from the state flop
	assign tuning_update_acknowledge = (state == ntw_pkg::ST_ACKED);

endmodule

// [core/ntw_regs.sv]
`timescale 1ns/1ps
// Summary of operation
// - Tuning word writes land in staging only
// - Request rising edge copies staging to working
// - Working value changes only on transfer
// - Acknowledge bit 1 high after transfer
// - Tuning word LSB first, bytes reset zero
module ntw_regs
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire ntw_pkg::ntw_access_t access,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic [2:0] interpolation_factor,
	output logic [3:0] interpolation_rate,
	output ntw_pkg::ntw_word_t frequency_tuning_word,
	output logic tuning_update_acknowledge
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Address compare used by write and read decode
	function automatic logic addr_hit(input logic [11:0] addr,
		input logic [11:0] offset);
		addr_hit = (addr == offset);
	endfunction

	// Only the four defined factor codes are accepted
	function automatic logic interp_legal(input logic [2:0] code);
		case (code)
			ntw_pkg::INTERP_1X: interp_legal = 1'b1;
			ntw_pkg::INTERP_2X: interp_legal = 1'b1;
			ntw_pkg::INTERP_4X: interp_legal = 1'b1;
			ntw_pkg::INTERP_8X: interp_legal = 1'b1;
			default: interp_legal = 1'b0;
		endcase
	endfunction

	// Factor code to one-hot rate for the interpolation chain
	function automatic logic [3:0] interp_rate(input logic [2:0] code);
		case (code)
			ntw_pkg::INTERP_1X: interp_rate = ntw_pkg::RATE_1X;
			ntw_pkg::INTERP_2X: interp_rate = ntw_pkg::RATE_2X;
			ntw_pkg::INTERP_4X: interp_rate = ntw_pkg::RATE_4X;
			ntw_pkg::INTERP_8X: interp_rate = ntw_pkg::RATE_8X;
			default: interp_rate = ntw_pkg::RATE_NONE;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------

	// Write enables per register
	logic wr_interp;
	logic wr_update;
	logic wr_tw0;
	logic wr_tw1;
	// Staging copy of the tuning word as the host wrote it
	ntw_pkg::ntw_word_t staged_word;
	// Host-owned update request bit
	logic tuning_update_request;
	// Transfer strobe from the handshake
	logic transfer_pulse;
	// Requested factor field of a write
	logic [2:0] wr_factor;
	// Readback value selected by address
	logic [7:0] next_read_data;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------

	// One enable per mapped offset; unmapped writes are dropped
	assign wr_interp = access.write
		&& addr_hit(access.addr, ntw_pkg::OFS_INTERP);
	assign wr_update = access.write
		&& addr_hit(access.addr, ntw_pkg::OFS_UPDATE);
	assign wr_tw0 = access.write
		&& addr_hit(access.addr, ntw_pkg::OFS_TW0);
	assign wr_tw1 = access.write
		&& addr_hit(access.addr, ntw_pkg::OFS_TW1);

	// Factor field out of the write data
	assign wr_factor = access.wdata[ntw_pkg::INTERP_MSB:ntw_pkg::INTERP_LSB];

	// ------------------------------------------------------------------
	// Interpolation factor select
	// ------------------------------------------------------------------

	// Takes effect at once; an undefined code leaves the old setting
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			interpolation_factor <= ntw_pkg::RST_INTERP;
		end
		else if (wr_interp && interp_legal(wr_factor))
		begin
			interpolation_factor <= wr_factor;
		end
	end

	// Rate decode from the held factor
	assign interpolation_rate = interp_rate(interpolation_factor);

	// ------------------------------------------------------------------
	// Update request bit
	// ------------------------------------------------------------------

	// Plain read/write bit; only the handshake reacts to its edges
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tuning_update_request <= 1'b0;
		end
		else if (wr_update)
		begin
			tuning_update_request <= access.wdata[ntw_pkg::BIT_REQ];
		end
	end

	// ------------------------------------------------------------------
	// Staging registers
	// ------------------------------------------------------------------

	// Byte 0 holds bits 7:0, byte 1 bits 15:8; one process owns both
	// so the staging word has a single driver
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			staged_word.byte0 <= ntw_pkg::RST_TW_BYTE;
			staged_word.byte1 <= ntw_pkg::RST_TW_BYTE;
		end
		else
		begin
			// Each byte has its own write enable
			if (wr_tw0)
			begin
				staged_word.byte0 <= access.wdata;
			end
			if (wr_tw1)
			begin
				staged_word.byte1 <= access.wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Update handshake
	// ------------------------------------------------------------------

	// Turns the request edge into a transfer and an acknowledge
	ntw_update_handshake u_handshake
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.tuning_update_request(tuning_update_request),
		.transfer_pulse(transfer_pulse),
		.tuning_update_acknowledge(tuning_update_acknowledge)
	);

	// ------------------------------------------------------------------
	// Working tuning word
	// ------------------------------------------------------------------

	// Loads only on the transfer strobe; a byte written in the same
	// cycle reaches staging but waits for the next request
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frequency_tuning_word.byte0 <= ntw_pkg::RST_TW_BYTE;
			frequency_tuning_word.byte1 <= ntw_pkg::RST_TW_BYTE;
		end
		else if (transfer_pulse)
		begin
			frequency_tuning_word <= staged_word;
		end
	end

	// ------------------------------------------------------------------
	// Readback
	// ------------------------------------------------------------------

	// Staging bytes read back; reserved bits and unmapped offsets read 0
	always_comb
	begin
		next_read_data = ntw_pkg::RST_READ;
		if (addr_hit(access.addr, ntw_pkg::OFS_INTERP))
		begin
			next_read_data[ntw_pkg::INTERP_MSB:ntw_pkg::INTERP_LSB] =
				interpolation_factor;
		end
		else if (addr_hit(access.addr, ntw_pkg::OFS_UPDATE))
		begin
			next_read_data[ntw_pkg::BIT_REQ] = tuning_update_request;
			// Acknowledge status for the host to poll
			next_read_data[ntw_pkg::BIT_ACK] =
				tuning_update_acknowledge;
		end
		else if (addr_hit(access.addr, ntw_pkg::OFS_TW0))
		begin
			next_read_data = staged_word.byte0;
		end
		else if (addr_hit(access.addr, ntw_pkg::OFS_TW1))
		begin
			next_read_data = staged_word.byte1;
		end
		else
		begin
			next_read_data = ntw_pkg::RST_READ;
		end
	end

	// Read data registered, valid one cycle after the read strobe
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			read_data <= ntw_pkg::RST_READ;
		end
		else if (access.read)
		begin
			read_data <= next_read_data;
		end
	end

	// Read valid strobe
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			read_valid <= 1'b0;
		end
		else
		begin
			read_valid <= access.read;
		end
	end

endmodule

// [test/ntw_regs_monitor.sv]
`timescale 1ns/1ps
// ----------------------------------------------
// Port checker for the tuning word register bank
// ----------------------------------------------
module ntw_regs_monitor
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire ntw_pkg::ntw_access_t access,
	input wire logic [7:0] read_data,
	input wire logic read_valid,
	input wire logic [2:0] interpolation_factor,
	input wire logic [3:0] interpolation_rate,
	input wire ntw_pkg::ntw_word_t frequency_tuning_word,
	input wire logic tuning_update_acknowledge
);
	logic req_m; // Mirror of the request bit
	logic [15:0] stg_m; // Mirror of the staging bytes
	logic hs_wr; // Write to the handshake register
	logic ack; // Short name for the acknowledge
	assign hs_wr = access.write && access.addr == ntw_pkg::OFS_UPDATE;
	assign ack = tuning_update_acknowledge;
	// Follow request and staging as the host writes them
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_m <= 1'b0;
			stg_m <= 16'h0000;
		end
		else
		begin
			if (hs_wr)
				req_m <= access.wdata[0];
			if (access.write && access.addr == ntw_pkg::OFS_TW0)
				stg_m[7:0] <= access.wdata;
			if (access.write && access.addr == ntw_pkg::OFS_TW1)
				stg_m[15:8] <= access.wdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Request bit written from zero to one
	sequence s_req_rise;
		hs_wr && access.wdata[0] && !req_m;
	endsequence
	// Request bit cleared while acknowledged
	sequence s_req_drop;
		hs_wr && !access.wdata[0] && req_m && ack;
	endsequence
	AST_ACK_SET: assert property (s_req_rise |=> !ack ##1 ack)
		else $error("ack not set two cycles after request");
	AST_ACK_CLR: assert property (s_req_drop |=> ack ##1 !ack)
		else $error("ack not cleared after request cleared");
	AST_TW_HOLD: assert property ($changed(frequency_tuning_word)
		|-> $rose(ack))
		else $error("working word changed without transfer");
	AST_TW_LOAD: assert property ($rose(ack)
		|-> frequency_tuning_word == $past(stg_m))
		else $error("working word differs from staging");
	AST_HS_READ: assert property (access.read
		&& access.addr == ntw_pkg::OFS_UPDATE |=> read_valid
		&& read_data == {6'h00, $past(ack), $past(req_m)})
		else $error("handshake readback wrong");
	AST_STG_READ: assert property (access.read
		&& access.addr == ntw_pkg::OFS_TW0
		|=> read_data == $past(stg_m[7:0]))
		else $error("staging readback wrong");
	AST_UNMAP: assert property (access.read && (access.addr < 12'h112
		|| access.addr > 12'h115) |=> read_valid && read_data == 8'h00)
		else $error("unmapped read not zero");
	AST_FACTOR: assert property ($changed(interpolation_factor)
		|-> $past(access.write && access.addr == ntw_pkg::OFS_INTERP))
		else $error("factor changed without write");
	AST_RATE: assert property (interpolation_rate ==
		(interpolation_factor == 3'h0 ? 4'h1 : interpolation_factor == 3'h1
		? 4'h2 : interpolation_factor == 3'h3 ? 4'h4 : 4'h8))
		else $error("rate does not match factor");
endmodule

bind ntw_regs ntw_regs_monitor ntw_regs_monitor_i (.mclk, .reset_n,
	.access, .read_data, .read_valid, .interpolation_factor,
	.interpolation_rate, .frequency_tuning_word, .tuning_update_acknowledge);

// [test/ntw_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Host model on the control port side
// ----------------------------------------
module ntw_host
(
	input wire logic mclk,
	output ntw_pkg::ntw_access_t access
);
	// Port idle at time zero
	initial access = '0;
	// One access, taken at the following edge
	task automatic xfer(input logic w, input logic r,
		input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		access <= '{write: w, read: r, addr: a, wdata: d};
	endtask
	// Release the port; stale data is inverted, not kept
	task automatic idle();
		@(posedge mclk);
		access <= '{1'b0, 1'b0, access.addr, ~access.wdata};
	endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the register bank
// ----------------------------------------
module tb_top;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	ntw_pkg::ntw_access_t access;
	logic [7:0] read_data;
	logic read_valid;
	logic [2:0] interpolation_factor;
	logic [3:0] interpolation_rate;
	ntw_pkg::ntw_word_t frequency_tuning_word;
	logic tuning_update_acknowledge;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	int fails = 0;
	int n_compared = 0;
	int seed;
	logic [15:0] tw_new; // Value being staged
	logic [15:0] tw_cur = 16'h0000; // Value last transferred
	logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h2};
	ntw_host ntw_host_i (.mclk(mclk), .access(access));
	ntw_regs ntw_regs_i (.mclk(mclk), .reset_n(reset_n), .access(access),
		.read_data(read_data), .read_valid(read_valid),
		.interpolation_factor(interpolation_factor),
		.interpolation_rate(interpolation_rate),
		.frequency_tuning_word(frequency_tuning_word),
		.tuning_update_acknowledge(tuning_update_acknowledge));
	initial forever #12.5 mclk = ~mclk;
	// Compare one output value
	task automatic cmp(input string what, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	// Compare one read result
	task automatic cmp_rd(input logic [7:0] e);
		cmp("read_data", {8'h00, e}, {8'h00, read_data});
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		ntw_host_i.xfer(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		ntw_host_i.xfer(1'b0, 1'b1, a, 8'h00);
	endtask
	// Idle the port and let n edges pass
	task automatic settle(input int n);
		ntw_host_i.idle();
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Bounded wait for the acknowledge level
	task automatic wait_ack(input logic v);
		for (int i = 0; i < 8 && tuning_update_acknowledge !== v; i++)
			@(posedge mclk) #1;
		cmp("ack", {15'h0, v}, {15'h0, tuning_update_acknowledge});
		// A wait that ran out ends the run at once
		if (tuning_update_acknowledge !== v)
			stop_test();
	endtask
	task automatic stop_test();
		if (exp_q.size() != 0)
			fails++;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Take the oldest note whenever a read answer appears
	always @(posedge mclk)
		if (read_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				cmp("read count", 16'h0000, 16'h0001);
			else
				cmp_rd(exp_q.pop_front());
		end
	// Main sequence
	initial
	begin
		seed = 32'h2a6b5334;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		rd(ntw_pkg::OFS_INTERP, 8'h01);
		rd(ntw_pkg::OFS_UPDATE, 8'h00);
		rd(ntw_pkg::OFS_TW0, 8'h00);
		rd(ntw_pkg::OFS_TW1, 8'h00);
		rd(12'h116, 8'h00);
		settle(2);
		cmp("tuning word", 16'h0000, frequency_tuning_word);
		$display("reset values done");
		// Every factor code, then an illegal one that must be ignored
		foreach (codes[i])
		begin
			wr(ntw_pkg::OFS_INTERP, {5'h1f, codes[i]});
			rd(ntw_pkg::OFS_INTERP, {5'h00, codes[i < 4 ? i : 3]});
			settle(2);
			cmp("rate", 16'h1 << (i < 4 ? i : 3),
				{12'h000, interpolation_rate});
			cmp("factor", {13'h0, codes[i < 4 ? i : 3]},
				{13'h0, interpolation_factor});
		end
		$display("factor codes done");
		for (int k = 0; k < 4; k++)
		begin
			tw_new = 16'($random(seed));
			wr(ntw_pkg::OFS_TW0, tw_new[7:0]);
			wr(ntw_pkg::OFS_TW1, tw_new[15:8]);
			rd(ntw_pkg::OFS_TW0, tw_new[7:0]);
			settle(2);
			cmp("held word", tw_cur, frequency_tuning_word);
			wr(ntw_pkg::OFS_UPDATE, 8'h01);
			settle(0);
			wait_ack(1'b1);
			cmp("new word", tw_new, frequency_tuning_word);
			tw_cur = tw_new;
			rd(ntw_pkg::OFS_UPDATE, 8'h03);
			wr(ntw_pkg::OFS_TW1, ~tw_new[15:8]);
			wr(ntw_pkg::OFS_UPDATE, 8'h01);
			settle(3);
			cmp("no edge", tw_cur, frequency_tuning_word);
			wr(ntw_pkg::OFS_UPDATE, 8'h00);
			settle(0);
			wait_ack(1'b0);
			rd(ntw_pkg::OFS_UPDATE, 8'h00);
			settle(2);
		end
		$display("update handshake done");
		// Mid-run reset, applied and released on clock edges
		@(posedge mclk);
		reset_n <= 1'b0;
		settle(2);
		@(posedge mclk);
		reset_n <= 1'b1;
		rd(ntw_pkg::OFS_TW1, 8'h00);
		settle(3);
		cmp("word after reset", 16'h0000, frequency_tuning_word);
		cmp("factor after reset", 16'h0001, {13'h0, interpolation_factor});
		cmp("ack after reset", 16'h0000,
			{15'h0, tuning_update_acknowledge});
		$display("second reset done");
		stop_test();
	end
endmodule
